// ==== logic/acp_pkg.sv ====
// package for the converter clock and power-down control block
// assumes a single ref_clk domain; shared by acp_ctrl and acp_conv_clk
`default_nettype none
package acp_pkg;
    // control byte field positions
    localparam int MODE_HI_BIT   = 7;
    localparam int MODE_LO_BIT   = 6;
    localparam int ACQ_STYLE_BIT = 5;
    localparam int RNG_BIT       = 4;
    localparam int BIP_BIT       = 3;
    // mode pair encodings
    localparam logic [1:0] MODE_EXT_CLK  = 2'h0;
    localparam logic [1:0] MODE_INT_CLK  = 2'h1;
    localparam logic [1:0] MODE_STANDBY  = 2'h2;
    localparam logic [1:0] MODE_FULL_PD  = 2'h3;
    // reset values
    localparam logic       RST_INT_CLK   = 1'b0;
    localparam logic [7:0] RST_CTRL_BYTE = 8'h00;
    // conversion timing in conversion-clock cycles
    localparam int CONV_CYCLES = 12;
    localparam int ACQ_CYCLES  = 6;
    // internal oscillator: divide ref_clk (100 MHz) down to about 1.56 MHz
    localparam int REF_CLK_HZ     = 100_000_000;
    localparam int INT_CLK_HZ     = 1_560_000;
    localparam int INT_CLK_HALF   = REF_CLK_HZ / (2 * INT_CLK_HZ);
    localparam int RESULT_BITS    = 12;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ACQ    = 3'h1,
        ST_EXTACQ = 3'h2,
        ST_CONV   = 3'h3,
        ST_PD     = 3'h4
    } acp_state_e;

    // control byte fields carried together
    typedef struct packed {
        logic [1:0] mode;
        logic       acq_ext;
        logic       rng;
        logic       bip;
        logic [2:0] chan;
    } acp_ctrl_s;
endpackage : acp_pkg
`default_nettype wire

// ==== logic/acp_conv_clk.sv ====
// conversion clock tick generator: internal divider or synchronised external pin
// assumes ext_clk is asynchronous to ref_clk and slower than ref_clk / 4
`default_nettype none
module acp_conv_clk #(
    parameter int HALF_PERIOD = acp_pkg::INT_CLK_HALF
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic use_int,
    input  wire logic run,
    input  wire logic ext_clk,
    output logic      tick
);
    initial begin
        if (HALF_PERIOD < 1) $error("HALF_PERIOD must be at least 1");
    end

    logic [15:0] div_q;
    logic        int_ph_q;
    logic        ext_s1_q;
    logic        ext_s2_q;
    logic        ext_s3_q;
    logic        div_wrap;
    logic        int_rise;
    logic        ext_rise;

    // divider wraps every half period; rising phase gives one tick
    assign div_wrap = (div_q == 16'(HALF_PERIOD - 1));
    assign int_rise = div_wrap & ~int_ph_q;
    // edge detect reads only the second and third stages
    assign ext_rise = ext_s2_q & ~ext_s3_q;

    // oscillator stops when idle to save power
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_q    <= 16'h0000;
            int_ph_q <= 1'b0;
        end else if (!run || !use_int) begin
            div_q    <= 16'h0000;
            int_ph_q <= 1'b0;
        end else if (div_wrap) begin
            div_q    <= 16'h0000;
            int_ph_q <= ~int_ph_q;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    // two-stage synchroniser plus edge history for the external pin
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_clk;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // both clock modes feed the same tick for either acquisition style
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tick <= 1'b0;
        end else begin
            tick <= run & (use_int ? int_rise : ext_rise);
        end
    end
endmodule : acp_conv_clk
`default_nettype wire

// ==== logic/acp_ctrl.sv ====
// converter control: clock mode, power-down, acquisition and result format
// assumes wr_n, rd_n, cs_n, hben, hw_shutdown_n and ext_clk are asynchronous pins;
// the analog SAR core answers sar_bit each conversion-clock tick
//
// Operation
// - mode bits choose internal or external clock
// - power-down bytes keep previous clock mode
// - either clock with either acquisition style
// - power-up: done high, external clock
// - mode 01 gives internal clock normal
// - mode 00 gives external clock normal
// - mode bits select standby or full power-down
// - software power-down waits for conversion end
// - bus stays alive in every power-down
// - write falling edge leaves software power-down
// - shutdown pin low: full power-down, abort
// - standby keeps buffer; full keeps bandgap only
// - standby each byte: no extra start-up
// - unipolar straight binary, bipolar two's complement
// - mode pair 00 ext 01 int 10 stby 11 full
// - conversion takes twelve conversion-clock cycles
// - done low on result, high on read/write
//
// The strobe port and its ref_clk synchronisers are this design's own decisions.
`default_nettype none
module acp_ctrl #(
    parameter int CONV_LEN = acp_pkg::CONV_CYCLES,
    parameter int ACQ_LEN  = acp_pkg::ACQ_CYCLES
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       cs_n,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    input  wire logic       hben,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       ext_clk,
    input  wire logic       hw_shutdown_n,
    input  wire logic       sar_bit,
    output logic            conv_done_n,
    output logic            int_clk_en,
    output logic            sample_hold,
    output logic            sar_step,
    output logic      [2:0] mux_chan,
    output logic            range_high,
    output logic            bipolar,
    output logic            ref_buffer_en,
    output logic            bandgap_en,
    output logic            standby_powerdown,
    output logic            full_powerdown
);
    //------------------------------------------------------------------
    // parameter checks
    //------------------------------------------------------------------
    initial begin
        if (CONV_LEN != acp_pkg::RESULT_BITS) $error("CONV_LEN must equal result width");
        if (ACQ_LEN < 1 || ACQ_LEN > 15) $error("ACQ_LEN out of range");
    end

    //------------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------------
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [7:0] data_s1_q;
    logic [7:0] data_s2_q;
    logic       wr_prev_q;
    logic       rd_prev_q;
    logic       cs_act;
    logic       wr_act;
    logic       rd_act;
    logic       hben_s;
    logic       hw_shutdown_n_act;
    logic       wr_fall;
    logic       wr_rise;
    logic       rd_fall;

    // pins pass two flip-flops before any logic reads them
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pin_s1_q  <= 5'h1f;
            pin_s2_q  <= 5'h1f;
            data_s1_q <= 8'h00;
            data_s2_q <= 8'h00;
        end else begin
            pin_s1_q  <= {cs_n, wr_n, rd_n, hben, hw_shutdown_n};
            pin_s2_q  <= pin_s1_q;
            data_s1_q <= data_in;
            data_s2_q <= data_s1_q;
        end
    end

    // strobe history for edge detection
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_prev_q <= 1'b0;
            rd_prev_q <= 1'b0;
        end else begin
            wr_prev_q <= wr_act;
            rd_prev_q <= rd_act;
        end
    end

    // cs gates both strobes; data taken from the sample aligned with the write strobe's rising edge
    assign cs_act   = ~pin_s2_q[4];
    assign wr_act   = cs_act & ~pin_s2_q[3];
    assign rd_act   = cs_act & ~pin_s2_q[2];
    assign hben_s   = pin_s2_q[1];
    assign hw_shutdown_n_act = ~pin_s2_q[0];
    assign wr_fall  = wr_act & ~wr_prev_q;
    assign wr_rise  = ~wr_act & wr_prev_q;
    assign rd_fall  = rd_act & ~rd_prev_q;

    //------------------------------------------------------------------
    // control byte decode
    //------------------------------------------------------------------
    acp_pkg::acp_ctrl_s byte_in;
    acp_pkg::acp_ctrl_s ctrl_q;
    logic               sel_clk_mode;
    logic               sel_pd;

    function automatic acp_pkg::acp_ctrl_s unpack_byte(input logic [7:0] b);
        acp_pkg::acp_ctrl_s s;
        s.mode    = b[acp_pkg::MODE_HI_BIT:acp_pkg::MODE_LO_BIT];
        s.acq_ext = b[acp_pkg::ACQ_STYLE_BIT];
        s.rng     = b[acp_pkg::RNG_BIT];
        s.bip     = b[acp_pkg::BIP_BIT];
        s.chan    = b[2:0];
        return s;
    endfunction : unpack_byte

    assign byte_in      = unpack_byte(data_s2_q);
    assign sel_clk_mode = ~byte_in.mode[1];
    assign sel_pd       = byte_in.mode[1];

    //------------------------------------------------------------------
    // clock mode and latched control byte
    //------------------------------------------------------------------
    logic use_int_q;
    logic pd_pending_q;
    logic pd_full_q;

    // byte latched at rising edge of the write strobe
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_q    <= acp_pkg::acp_ctrl_s'(acp_pkg::RST_CTRL_BYTE);
            use_int_q <= acp_pkg::RST_INT_CLK;
        end else if (wr_rise) begin
            ctrl_q <= byte_in;
            if (sel_clk_mode) begin
                use_int_q <= (byte_in.mode == acp_pkg::MODE_INT_CLK);
            end
            // power-down bytes leave use_int_q untouched
        end
    end

    //------------------------------------------------------------------
    // acquisition and conversion sequencer
    //------------------------------------------------------------------
    acp_pkg::acp_state_e state_q;
    acp_pkg::acp_state_e state_d;
    logic [3:0]          cnt_q;
    logic [11:0]         result_q;
    logic [11:0]         shift_q;
    logic                tick;
    logic                run;
    logic                acq_last;
    logic                conv_last;

    // clock only ticks while a sequence needs it
    assign run       = (state_q == acp_pkg::ST_ACQ) || (state_q == acp_pkg::ST_CONV);
    assign acq_last  = tick && (cnt_q == 4'(ACQ_LEN - 1));
    assign conv_last = tick && (cnt_q == 4'(CONV_LEN - 1));

    acp_conv_clk #(
        .HALF_PERIOD (acp_pkg::INT_CLK_HALF)
    ) u_conv_clk (
        .ref_clk (ref_clk),
        .reset   (reset),
        .use_int (use_int_q),
        .run     (run),
        .ext_clk (ext_clk),
        .tick    (tick)
    );

    // either acquisition style runs under either clock
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            acp_pkg::ST_IDLE: begin
                if (wr_rise) begin
                    state_d = byte_in.acq_ext ? acp_pkg::ST_EXTACQ : acp_pkg::ST_ACQ;
                end
            end
            // wake on the write's falling edge; its rising edge then starts acquisition
            acp_pkg::ST_PD: begin
                if (wr_fall) begin
                    state_d = acp_pkg::ST_IDLE;
                end
            end
            acp_pkg::ST_ACQ: begin
                if (wr_rise) begin
                    state_d = byte_in.acq_ext ? acp_pkg::ST_EXTACQ : acp_pkg::ST_ACQ;
                end else if (acq_last) begin
                    state_d = acp_pkg::ST_CONV;
                end
            end
            acp_pkg::ST_EXTACQ: begin
                if (wr_rise) begin
                    state_d = byte_in.acq_ext ? acp_pkg::ST_EXTACQ : acp_pkg::ST_CONV;
                end
            end
            acp_pkg::ST_CONV: begin
                if (wr_rise) begin
                    state_d = byte_in.acq_ext ? acp_pkg::ST_EXTACQ : acp_pkg::ST_ACQ;
                end else if (conv_last) begin
                    state_d = pd_pending_q ? acp_pkg::ST_PD : acp_pkg::ST_IDLE;
                end
            end
            default: state_d = acp_pkg::ST_IDLE;
        endcase
        // hardware shutdown aborts whatever is running
        if (hw_shutdown_n_act) begin
            state_d = acp_pkg::ST_PD;
        end
    end

    // a stray write edge after shutdown release is needed to restart
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= acp_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // step counter restarts on every state change
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 4'h0;
        end else if (state_d != state_q || wr_rise) begin
            cnt_q <= 4'h0;
        end else if (tick) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    // successive approximation: one bit per conversion-clock tick, msb first
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            shift_q  <= 12'h000;
            result_q <= 12'h000;
        end else if (state_q == acp_pkg::ST_CONV && tick && !wr_rise && !hw_shutdown_n_act) begin
            shift_q <= {shift_q[10:0], sar_bit};
            if (conv_last) begin
                result_q <= {shift_q[10:0], sar_bit};
            end
        end
    end

    //------------------------------------------------------------------
    // power-down control
    //------------------------------------------------------------------
    logic conv_end;

    assign conv_end = (state_q == acp_pkg::ST_CONV) && (state_d != acp_pkg::ST_CONV)
                      && !wr_rise && !hw_shutdown_n_act;

    // pending request taken from the last byte; the next write falling edge wakes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pd_pending_q <= 1'b0;
            pd_full_q    <= 1'b0;
        end else if (wr_fall) begin
            pd_pending_q <= 1'b0;
        end else if (wr_rise) begin
            pd_pending_q <= sel_pd;
            pd_full_q    <= (byte_in.mode == acp_pkg::MODE_FULL_PD);
        end
    end

    // power outputs; shutdown pin forces full power-down at once
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            standby_powerdown <= 1'b0;
            full_powerdown    <= 1'b0;
            ref_buffer_en     <= 1'b1;
            bandgap_en        <= 1'b1;
        end else begin
            standby_powerdown <= (state_d == acp_pkg::ST_PD) && !hw_shutdown_n_act && !pd_full_q;
            full_powerdown    <= (state_d == acp_pkg::ST_PD) && (hw_shutdown_n_act || pd_full_q);
            ref_buffer_en     <= !((state_d == acp_pkg::ST_PD) && (hw_shutdown_n_act || pd_full_q));
            bandgap_en        <= 1'b1;
        end
    end

    //------------------------------------------------------------------
    // analog core drive
    //------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            int_clk_en  <= 1'b0;
            sample_hold <= 1'b0;
            sar_step    <= 1'b0;
            mux_chan    <= 3'h0;
            range_high  <= 1'b0;
            bipolar     <= 1'b0;
        end else begin
            // keeps oscillator off the external clock driver in ext mode
            int_clk_en  <= use_int_q && (state_d == acp_pkg::ST_ACQ || state_d == acp_pkg::ST_CONV);
            sample_hold <= (state_d == acp_pkg::ST_CONV);
            sar_step    <= (state_q == acp_pkg::ST_CONV) && tick;
            mux_chan    <= ctrl_q.chan;
            range_high  <= ctrl_q.rng;
            bipolar     <= ctrl_q.bip;
        end
    end

    //------------------------------------------------------------------
    // done flag and read port
    //------------------------------------------------------------------
    logic [7:0] rd_byte;

    // high byte sign-extended in bipolar, zero-filled in unipolar
    assign rd_byte = hben_s ? {{4{ctrl_q.bip & result_q[11]}}, result_q[11:8]}
                            : result_q[7:0];

    // result ready wins over a clear in the same cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            conv_done_n <= 1'b1;
        end else if (conv_end) begin
            conv_done_n <= 1'b0;
        end else if (rd_fall || wr_fall) begin
            conv_done_n <= 1'b1;
        end
    end

    // read port serves in every state, power-down included
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else begin
            data_out <= rd_byte;
            data_oe  <= rd_act;
        end
    end
endmodule : acp_ctrl
`default_nettype wire

// ==== dv/acp_checker.sv ====
// checker of acp_ctrl port behaviour
// assumes the single ref_clk domain; bound to every acp_ctrl
`default_nettype none
module acp_checker #(
    parameter int CONV_LEN = 12
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic hw_shutdown_n,
    input wire logic conv_done_n,
    input wire logic int_clk_en,
    input wire logic sample_hold,
    input wire logic sar_step,
    input wire logic ref_buffer_en,
    input wire logic bandgap_en,
    input wire logic standby_powerdown,
    input wire logic full_powerdown
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // ----------------------------------------
    // step counter
    // ----------------------------------------
    logic       sh_q;
    logic [4:0] steps_q;
    logic [4:0] steps_d;
    // restart on sample-hold rise so steps of earlier conversions never count
    assign steps_d = (sample_hold && !sh_q) ? 5'(sar_step) : steps_q + 5'(sar_step);
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sh_q    <= 1'b0;
            steps_q <= 5'h00;
        end else begin
            sh_q    <= sample_hold;
            steps_q <= steps_d;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    reset_state_a: assert property ($fell(reset) |-> conv_done_n && !int_clk_en)
        else $error("done or internal clock active after reset");
    pd_exclusive_a: assert property (!(standby_powerdown && full_powerdown))
        else $error("both power-down levels high");
    standby_buffer_a: assert property (standby_powerdown |-> ref_buffer_en && bandgap_en)
        else $error("standby lost a reference stage");
    full_buffer_a: assert property (full_powerdown |-> !ref_buffer_en && bandgap_en)
        else $error("full power-down stage levels wrong");
    pd_after_conv_a: assert property ($rose(standby_powerdown) && !$past(full_powerdown)
        |-> $fell(conv_done_n))
        else $error("standby entered mid conversion");
    shutdown_abort_a: assert property ($fell(hw_shutdown_n) |-> ##[1:4] (full_powerdown && !sample_hold))
        else $error("shutdown pin not obeyed");
    write_wakes_a: assert property ($fell(wr_n) && !cs_n && hw_shutdown_n && standby_powerdown
        |-> ##[1:5] !standby_powerdown)
        else $error("write did not wake from standby");
    done_read_a: assert property ($fell(rd_n) && !cs_n && !conv_done_n |-> ##[1:4] conv_done_n)
        else $error("read did not clear done");
    done_write_a: assert property ($fell(wr_n) && !cs_n && !conv_done_n |-> ##[1:5] conv_done_n)
        else $error("write did not clear done");
    conv_length_a: assert property ($fell(conv_done_n) |-> ##[0:2] steps_q == 5'(CONV_LEN))
        else $error("conversion step count wrong");
endmodule : acp_checker
bind acp_ctrl acp_checker #(.CONV_LEN(CONV_LEN)) u_chk (
    .ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .hw_shutdown_n(hw_shutdown_n), .conv_done_n(conv_done_n), .int_clk_en(int_clk_en),
    .sample_hold(sample_hold), .sar_step(sar_step), .ref_buffer_en(ref_buffer_en),
    .bandgap_en(bandgap_en), .standby_powerdown(standby_powerdown), .full_powerdown(full_powerdown)
);
`default_nettype wire

// ==== dv/acp_far_model.sv ====
// far side model: host conversion clock and comparator
// assumes ref_clk at 100 MHz; the code under test comes from the bench
`default_nettype none
module acp_far_model (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        sample_hold,
    input  wire logic        sar_step,
    input  wire logic [11:0] code,
    output logic             ext_clk,
    output logic             sar_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] bit_q;
    // 2 MHz at even duty, phase unrelated to ref_clk
    initial begin
        ext_clk = 1'b0;
        #3.3;
        forever #250 ext_clk = ~ext_clk;
    end
    // comparator walks the code msb first, one bit per step
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bit_q <= 4'h0;
        end else if (!sample_hold) begin
            bit_q <= 4'h0;
        end else if (sar_step) begin
            bit_q <= bit_q + 4'h1;
        end
    end
    // past the last bit the line toggles so no stale value is trusted
    assign sar_bit = (bit_q < 4'hc) ? code[4'hb - bit_q] : bit_q[0];
endmodule : acp_far_model
`default_nettype wire

// ==== dv/adc_clock_powerdown_control_tb_top.sv ====
// bench for acp_ctrl with the far side model
// assumes the checker is bound to acp_ctrl
`default_nettype none
module adc_clock_powerdown_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] CODE = 12'hb6d;
    logic       ref_clk, reset, cs_n, wr_n, rd_n, hben, hw_shutdown_n, ext_clk, sar_bit;
    logic       conv_done_n, int_clk_en, sample_hold, sar_step, range_high, bipolar;
    logic       data_oe, ref_buffer_en, bandgap_en, standby_powerdown, full_powerdown;
    logic [7:0] data_in, data_out, rv;
    logic [2:0] mux_chan;
    logic       saw_int;
    int         fails, samples_checked, cycles;
    acp_ctrl dut (
        .ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .hben(hben),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ext_clk(ext_clk),
        .hw_shutdown_n(hw_shutdown_n), .sar_bit(sar_bit), .conv_done_n(conv_done_n),
        .int_clk_en(int_clk_en), .sample_hold(sample_hold), .sar_step(sar_step), .mux_chan(mux_chan),
        .range_high(range_high), .bipolar(bipolar), .ref_buffer_en(ref_buffer_en),
        .bandgap_en(bandgap_en), .standby_powerdown(standby_powerdown), .full_powerdown(full_powerdown)
    );
    acp_far_model far (
        .ref_clk(ref_clk), .reset(reset), .sample_hold(sample_hold), .sar_step(sar_step),
        .code(CODE), .ext_clk(ext_clk), .sar_bit(sar_bit)
    );
    // ----------------------------------------
    // clock, watchdog, helpers
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // the watchdog also notes any oscillator activity
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (int_clk_en === 1'b1) saw_int <= 1'b1;
        if (cycles > 40000) begin
            fails++;
            test_done();
        end
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // write strobe held 4 cycles, read strobe 6: the pins pass a 2-stage synchroniser
    task automatic bus_write(input logic [7:0] b);
        saw_int = 1'b0;
        cs_n    <= 1'b0;
        wr_n    <= 1'b0;
        data_in <= b;
        repeat (4) @(posedge ref_clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask : bus_write
    task automatic bus_read(input logic hb, output logic [7:0] v);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        hben <= hb;
        repeat (5) @(posedge ref_clk);
        #1 v = data_out;
        check(data_oe, 1'b1);
        @(posedge ref_clk);
        rd_n <= 1'b1;
        cs_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask : bus_read
    task automatic wait_on(input logic want_done);
        for (int n = 0; n < 3000; n++) begin
            if (want_done ? (conv_done_n === 1'b0) : (sample_hold === 1'b1)) break;
            @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
    endtask : wait_on
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_int_unipolar();
        bus_write(8'h45);
        wait_on(1'b1);
        check(conv_done_n, 1'b0);
        check(saw_int, 1'b1);
        check(mux_chan, 3'h5);
        bus_read(1'b0, rv);
        check(rv, CODE[7:0]);
        check(conv_done_n, 1'b1);
        bus_read(1'b1, rv);
        check(rv, {4'h0, CODE[11:8]});
    endtask : s_int_unipolar
    task automatic s_ext_acquire(input logic [7:0] first, input logic intc);
        bus_write(first);
        bus_write(first & 8'hdf);
        wait_on(1'b1);
        check(conv_done_n, 1'b0);
        check(saw_int, intc);
        check({range_high, bipolar, mux_chan}, first[4:0]);
        bus_read(1'b1, rv);
        check(rv, first[3] ? {{4{CODE[11]}}, CODE[11:8]} : {4'h0, CODE[11:8]});
    endtask : s_ext_acquire
    task automatic s_powerdown();
        bus_write(8'h41);
        wait_on(1'b1);
        bus_write(8'h81);
        wait_on(1'b0);
        check(standby_powerdown, 1'b0);
        wait_on(1'b1);
        check({standby_powerdown, ref_buffer_en, bandgap_en}, 3'h7);
        check(saw_int, 1'b1);
        bus_read(1'b0, rv);
        check(rv, CODE[7:0]);
        bus_write(8'h81);
        check(standby_powerdown, 1'b0);
        wait_on(1'b1);
        check({conv_done_n, standby_powerdown}, 2'h1);
        bus_write(8'hc0);
        wait_on(1'b1);
        check({full_powerdown, ref_buffer_en, bandgap_en}, 3'h5);
        bus_write(8'h80);
        wait_on(1'b1);
        check({full_powerdown, standby_powerdown}, 2'h1);
        bus_write(8'h40);
        wait_on(1'b1);
        check({conv_done_n, full_powerdown, standby_powerdown}, 3'h0);
    endtask : s_powerdown
    task automatic s_shutdown();
        logic started;
        bus_write(8'h40);
        wait_on(1'b0);
        hw_shutdown_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check({full_powerdown, sample_hold}, 2'h2);
        repeat (2000) @(posedge ref_clk);
        check(conv_done_n, 1'b1);
        hw_shutdown_n <= 1'b1;
        started = 1'b0;
        repeat (1500) begin
            @(posedge ref_clk);
            if (sample_hold !== 1'b0) started = 1'b1;
        end
        check(started, 1'b0);
        bus_write(8'h00);
        wait_on(1'b1);
        check({conv_done_n, int_clk_en, full_powerdown}, 3'h0);
    endtask : s_shutdown
    task automatic test_done();
        $display("comparisons %0d, fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {cs_n, wr_n, rd_n, hw_shutdown_n} = 4'hf;
        {reset, hben, saw_int} = 3'h4;
        data_in = 8'h00;
        {fails, samples_checked, cycles} = '0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check({conv_done_n, int_clk_en, ref_buffer_en, bandgap_en, standby_powerdown, full_powerdown},
              6'h2c);
        s_int_unipolar();
        s_ext_acquire(8'h3a, 1'b0);
        s_ext_acquire(8'h6b, 1'b1);
        s_powerdown();
        s_shutdown();
        test_done();
    end
endmodule : adc_clock_powerdown_control_tb_top
`default_nettype wire
